/* File: include/acf_pkg.sv */
// shared constants, register map and carrier types for the converter control
package acf_pkg;

  // serial frame layout: rw bit, 7-bit address, 8-bit data, msb first
  localparam int FRAME_BITS    = 16;
  localparam int ADDR_BITS     = 7;
  localparam int DATA_BITS     = 8;
  localparam int CNT_BITS      = 5;
  localparam logic [CNT_BITS-1:0] RW_ADDR_DONE = 5'h08;
  localparam logic [CNT_BITS-1:0] FRAME_DONE   = 5'h10;

  // register offsets
  localparam logic [ADDR_BITS-1:0] OFS_MODE        = 7'h00;
  localparam logic [ADDR_BITS-1:0] OFS_DELAY_CTRL  = 7'h01;
  localparam logic [ADDR_BITS-1:0] OFS_DELAY_COARS = 7'h02;
  localparam logic [ADDR_BITS-1:0] OFS_DELAY_FINE  = 7'h03;
  localparam logic [ADDR_BITS-1:0] OFS_GAIN        = 7'h04;
  localparam logic [ADDR_BITS-1:0] OFS_OFFSET_LO   = 7'h05;
  localparam logic [ADDR_BITS-1:0] OFS_OFFSET_HI   = 7'h06;
  localparam logic [ADDR_BITS-1:0] OFS_STATUS      = 7'h07;

  // mode register field positions
  localparam int MODE_TWO_PORT_POS  = 0;
  localparam int MODE_HIGH_SPD_POS  = 1;
  localparam int MODE_TEST_EN_POS   = 2;
  localparam int MODE_TEST_SEL_POS  = 3;
  localparam int MODE_EDGE_RISE_POS = 5;
  localparam int MODE_TRIGGER_POS   = 6;

  // test pattern selection codes
  typedef enum logic [1:0] {
    ACF_PAT_ALL_LOW  = 2'h0,
    ACF_PAT_ALL_HIGH = 2'h1,
    ACF_PAT_ALIGN    = 2'h2
  } acf_pattern_type;

  // reset values
  localparam logic [DATA_BITS-1:0] MODE_RESET   = 8'h01;
  localparam logic [1:0]           COARSE_RESET = 2'h0;
  localparam logic [7:0]           FINE_RESET   = 8'h00;
  localparam logic [7:0]           GAIN_RESET   = 8'h80;
  localparam logic [9:0]           OFFSET_RESET = 10'h200;

  // delay arithmetic: one coarse step equals this many fine steps
  localparam logic [9:0] FINE_PER_COARSE = 10'h0ff;
  localparam int         ALIGN_PERIOD    = 16;

  // configuration carrier
  typedef struct packed {
    logic            two_port;
    logic            high_speed;
    logic            test_en;
    acf_pattern_type test_sel;
    logic            edge_rising;
    logic            trigger;
  } acf_cfg_type;

  // output sample carrier
  typedef struct packed {
    logic [11:0] port_a;
    logic [11:0] port_b;
    logic        b_valid;
  } acf_out_type;

endpackage

/* File: design/acf_top.sv */
// converter configuration, serial register access and output formatting
`timescale 1ns/1ps

// Contract
// - two demultiplex ratios, single-port or two-port, set by config.
// - single-port ratio puts every sample, in order, on port A.
// - two-port ratio puts even samples on A, odd samples on B.
// - ratio selects two-port after reset.
// - high-speed single-port option, off after reset.
// - test mode replaces data with all low, all high or align; off.
// - alignment pattern repeats every 16 output-data-rate cycles.
// - resync active edge selectable, rising or falling; falling at reset.
// - trigger or synchronisation behaviour; synchronisation at reset.
// - delay trim disabled after reset; nominal aperture delay applies.
// - 2-bit coarse delay adds 0, 30, 60 or 90 ps.
// - 8-bit fine delay adds about 0.12 ps steps up to 30 ps.
// - applied delay is coarse plus fine, range 0 to 120 ps.
// - gain trim reaches unity gain with 0.8 LSB step.
// - offset trim spans plus or minus 195 LSB, 0.38 LSB step.
// - resync input active low, asynchronous, re-registered before use.
// - each setting takes effect immediately when written.
module acf_top #(
  parameter int SAMPLE_W = 12
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // three wire serial interface pins
  input  wire logic                 serial_clk,
  input  wire logic                 serial_csn,
  input  wire logic                 serial_data_in,
  output logic                      serial_data_out,
  output logic                      serial_data_oe,
  // resynchronisation pin, active low
  input  wire logic                 resync_n,
  // samples from the converter core
  input  wire logic [SAMPLE_W-1:0]  sample_data,
  input  wire logic                 sample_valid,
  // formatted output ports
  output acf_pkg::acf_out_type      out_data,
  output logic                      out_valid,
  // analogue trim and mode controls
  output logic                      high_speed_single_port,
  output logic [9:0]                aperture_delay_code,
  output logic [7:0]                gain_trim_code,
  output logic [9:0]                offset_trim_code
);
  import acf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [1:0] sclk_sync_r;
  logic [1:0] csn_sync_r;
  logic [1:0] sdin_sync_r;
  logic [1:0] resync_sync_r;
  logic       sclk_prev_r;
  logic       resync_prev_r;

  // resynchronisation re-latched to the sampling clock
  // re-registered resync
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_sync_r   <= 2'h0;
      csn_sync_r    <= 2'h3;
      sdin_sync_r   <= 2'h0;
      resync_sync_r <= 2'h3;
      sclk_prev_r   <= 1'b0;
      resync_prev_r <= 1'b1;
    end else begin
      sclk_sync_r   <= {sclk_sync_r[0], serial_clk};
      csn_sync_r    <= {csn_sync_r[0], serial_csn};
      sdin_sync_r   <= {sdin_sync_r[0], serial_data_in};
      resync_sync_r <= {resync_sync_r[0], resync_n};
      sclk_prev_r   <= sclk_sync_r[1];
      resync_prev_r <= resync_sync_r[1];
    end
  end

  // edges seen only on second-stage outputs
  wire sclk_rise = sclk_sync_r[1] & ~sclk_prev_r;
  wire sclk_fall = ~sclk_sync_r[1] & sclk_prev_r;
  wire csn_s     = csn_sync_r[1];
  wire sdin_s    = sdin_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // serial frame engine

  logic [CNT_BITS-1:0]   bit_cnt_r;
  logic [FRAME_BITS-1:0] shift_in_r;
  logic [DATA_BITS-1:0]  shift_out_r;
  logic                  read_active_r;

  wire [FRAME_BITS-1:0] shift_in_nxt = {shift_in_r[FRAME_BITS-2:0], sdin_s};
  wire                  hdr_done     = sclk_rise & ~csn_s &
                                       (bit_cnt_r == RW_ADDR_DONE - 5'h01);
  wire                  frame_end    = sclk_rise & ~csn_s &
                                       (bit_cnt_r == FRAME_DONE - 5'h01);
  // rw bit high means read; header is rw plus address
  wire                  hdr_read     = shift_in_nxt[ADDR_BITS];
  wire [ADDR_BITS-1:0]  hdr_addr     = shift_in_nxt[ADDR_BITS-1:0];
  wire                  frame_read   = shift_in_r[FRAME_BITS-2];
  wire [ADDR_BITS-1:0]  wr_addr      = shift_in_nxt[FRAME_BITS-2:DATA_BITS];
  wire [DATA_BITS-1:0]  wr_data      = shift_in_nxt[DATA_BITS-1:0];
  wire                  wr_strobe    = frame_end & ~frame_read;

  // bit counter and input shifter; csn high aborts any partial frame
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r  <= '0;
      shift_in_r <= '0;
    end else if (csn_s) begin
      bit_cnt_r  <= '0;
    end else if (sclk_rise) begin
      bit_cnt_r  <= (bit_cnt_r == FRAME_DONE - 5'h01) ? '0
                                                      : bit_cnt_r + 5'h01;
      shift_in_r <= shift_in_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [DATA_BITS-1:0] mode_r;
  logic                 delay_en_r;
  logic [1:0]           coarse_r;
  logic [7:0]           fine_r;
  logic [7:0]           gain_r;
  logic [9:0]           offset_r;

  // write commits at the last bit, no separate apply step
  // immediate register write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_r     <= MODE_RESET;
      delay_en_r <= 1'b0;
      coarse_r   <= COARSE_RESET;
      fine_r     <= FINE_RESET;
      gain_r     <= GAIN_RESET;
      offset_r   <= OFFSET_RESET;
    end else if (wr_strobe) begin
      unique case (wr_addr)
        OFS_MODE:        mode_r        <= wr_data;
        OFS_DELAY_CTRL:  delay_en_r    <= wr_data[0];
        OFS_DELAY_COARS: coarse_r      <= wr_data[1:0];
        OFS_DELAY_FINE:  fine_r        <= wr_data;
        OFS_GAIN:        gain_r        <= wr_data;
        OFS_OFFSET_LO:   offset_r[7:0] <= wr_data;
        OFS_OFFSET_HI:   offset_r[9:8] <= wr_data[1:0];
        default:         ;
      endcase
    end
  end

  // decoded configuration
  // ratio select
  acf_cfg_type cfg;
  assign cfg.two_port    = mode_r[MODE_TWO_PORT_POS];
  assign cfg.high_speed  = mode_r[MODE_HIGH_SPD_POS];
  assign cfg.test_en     = mode_r[MODE_TEST_EN_POS];
  assign cfg.test_sel    = acf_pattern_type'(mode_r[MODE_TEST_SEL_POS +: 2]);
  assign cfg.edge_rising = mode_r[MODE_EDGE_RISE_POS];
  assign cfg.trigger     = mode_r[MODE_TRIGGER_POS];

  ////////////////////////////////////////////////////////////////////////////
  // read back

  logic [DATA_BITS-1:0] status_w;
  logic [DATA_BITS-1:0] rd_data;

  // unmapped addresses read as zero
  function automatic logic [DATA_BITS-1:0] read_mux(
    input logic [ADDR_BITS-1:0] addr
  );
    logic [DATA_BITS-1:0] v;
    v = '0;
    unique case (addr)
      OFS_MODE:        v = mode_r;
      OFS_DELAY_CTRL:  v = {7'h00, delay_en_r};
      OFS_DELAY_COARS: v = {6'h00, coarse_r};
      OFS_DELAY_FINE:  v = fine_r;
      OFS_GAIN:        v = gain_r;
      OFS_OFFSET_LO:   v = offset_r[7:0];
      OFS_OFFSET_HI:   v = {6'h00, offset_r[9:8]};
      OFS_STATUS:      v = status_w;
      default:         v = '0;
    endcase
    return v;
  endfunction

  assign rd_data = read_mux(hdr_addr);

  // read data driven from the rising edge ending the header, msb first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_out_r   <= '0;
      read_active_r <= 1'b0;
    end else if (csn_s || frame_end) begin
      read_active_r <= 1'b0;
    end else if (hdr_done && hdr_read) begin
      shift_out_r   <= rd_data;
      read_active_r <= 1'b1;
    end else if (sclk_fall && read_active_r &&
                 bit_cnt_r != RW_ADDR_DONE) begin
      shift_out_r   <= {shift_out_r[DATA_BITS-2:0], 1'b0};
    end
  end

  // enable held for the data half of a read frame only
  assign serial_data_out = shift_out_r[DATA_BITS-1];
  assign serial_data_oe  = read_active_r;

  ////////////////////////////////////////////////////////////////////////////
  // resynchronisation and trigger handling

  logic armed_r;
  logic sync_seen_r;

  wire resync_s    = resync_sync_r[1];
  wire resync_edge = cfg.edge_rising ? (resync_s & ~resync_prev_r)
                                     : (~resync_s & resync_prev_r);
  wire resync_hold = ~resync_s & ~cfg.trigger;

  // trigger mode waits for an edge before streaming; sync mode restarts
  // trigger versus sync
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      armed_r     <= 1'b0;
      sync_seen_r <= 1'b0;
    end else begin
      if (resync_edge) begin
        armed_r     <= 1'b1;
        sync_seen_r <= 1'b1;
      end else if (!cfg.trigger) begin
        armed_r     <= 1'b0;
      end
    end
  end

  wire run = cfg.trigger ? armed_r : ~resync_hold;

  ////////////////////////////////////////////////////////////////////////////
  // output formatting

  logic [SAMPLE_W-1:0] even_r;
  logic                phase_r;
  logic [3:0]          align_cnt_r;
  acf_out_type         out_r;
  logic                out_valid_r;

  function automatic logic [SAMPLE_W-1:0] pattern(
    input acf_pattern_type sel,
    input logic [3:0]      cnt
  );
    logic [SAMPLE_W-1:0] p;
    p = '0;
    unique case (sel)
      ACF_PAT_ALL_LOW:  p = '0;
      ACF_PAT_ALL_HIGH: p = '1;
      ACF_PAT_ALIGN:    p = {3{cnt}};
      default:          p = '0;
    endcase
    return p;
  endfunction

  wire [SAMPLE_W-1:0] pat_a = pattern(cfg.test_sel, align_cnt_r);
  wire [SAMPLE_W-1:0] pat_b = pattern(cfg.test_sel, ~align_cnt_r);
  wire                take  = sample_valid & run;
  wire                emit  = take & (~cfg.two_port | phase_r);
  // resync edge in sync mode restarts even/odd phase and pattern period
  wire                restart = resync_edge & ~cfg.trigger;

  // even on a, odd on b
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      even_r  <= '0;
      phase_r <= 1'b0;
    end else if (restart || !run) begin
      phase_r <= 1'b0;
    end else if (take) begin
      even_r  <= sample_data;
      phase_r <= cfg.two_port & ~phase_r;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      align_cnt_r <= '0;
    end else if (restart) begin
      align_cnt_r <= '0;
    end else if (emit) begin
      align_cnt_r <= align_cnt_r + 4'h1;
    end
  end

  // outputs registered; port b only carries data in two-port ratio
  // pattern replaces data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_r       <= '0;
      out_valid_r <= 1'b0;
    end else begin
      out_valid_r <= emit;
      if (emit) begin
        out_r.b_valid <= cfg.two_port;
        if (cfg.test_en) begin
          out_r.port_a <= pat_a;
          out_r.port_b <= cfg.two_port ? pat_b : '0;
        end else if (cfg.two_port) begin
          out_r.port_a <= even_r;
          out_r.port_b <= sample_data;
        end else begin
          out_r.port_a <= sample_data;
          out_r.port_b <= '0;
        end
      end
    end
  end

  assign out_data  = out_r;
  assign out_valid = out_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // trim and mode controls

  logic [9:0] delay_r;
  logic [7:0] gain_out_r;
  logic [9:0] offset_out_r;
  logic       hs_r;

  // coarse step weighs one full fine span, 0.1176 ps a code
  // coarse contribution
  wire [9:0] coarse_steps = 10'(coarse_r) * FINE_PER_COARSE;
  wire [9:0] delay_total  = coarse_steps + 10'(fine_r);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      delay_r      <= '0;
      gain_out_r   <= GAIN_RESET;
      offset_out_r <= OFFSET_RESET;
      hs_r         <= 1'b0;
    end else begin
      delay_r      <= delay_en_r ? delay_total : '0;
      gain_out_r   <= gain_r;
      offset_out_r <= offset_r;
      hs_r         <= cfg.high_speed & ~cfg.two_port;
    end
  end

  assign aperture_delay_code    = delay_r;
  assign gain_trim_code         = gain_out_r;
  assign offset_trim_code       = offset_out_r;
  assign high_speed_single_port = hs_r;

  // status: live block state for read back
  assign status_w = {4'h0, armed_r, sync_seen_r, phase_r, resync_s};

endmodule

/* File: dv/acf_top_sva.sv */
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module acf_top_sva (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 resetn,
  // serial pins
  input wire logic                 serial_csn,
  input wire logic                 serial_data_oe,
  // sample stream
  input wire logic                 sample_valid,
  input wire acf_pkg::acf_out_type out_data,
  input wire logic                 out_valid,
  // trim and mode outputs
  input wire logic                 high_speed_single_port,
  input wire logic [9:0]           aperture_delay_code,
  input wire logic [7:0]           gain_trim_code,
  input wire logic [9:0]           offset_trim_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // frame select idle long enough to pass the synchronisers
  sequence csn_idle;
    serial_csn [*5];
  endsequence

  // read data phase lasts many clocks
  sequence oe_burst;
    serial_data_oe [*8];
  endsequence

  a_out_cause: assert property (
    out_valid |-> $past(sample_valid)) else $error("output without sample");
  a_hs_no_b: assert property (
    high_speed_single_port && out_valid |-> !out_data.b_valid)
    else $error("port b used in fast single port");
  a_out_hold: assert property (
    !out_valid |-> $stable(out_data)) else $error("output moved unmarked");
  a_oe_holds: assert property (
    $rose(serial_data_oe) |-> oe_burst) else $error("read drive too short");
  a_oe_release: assert property (
    csn_idle |-> !serial_data_oe) else $error("drive while deselected");
  a_trim_steady: assert property (
    csn_idle |=> $stable(gain_trim_code) && $stable(offset_trim_code)
      && $stable(aperture_delay_code)) else $error("trim moved idle");
  a_delay_max: assert property (
    aperture_delay_code <= 10'h3fc) else $error("delay beyond range");
  a_reset_vals: assert property (
    $rose(resetn) |-> gain_trim_code == 8'h80 && offset_trim_code == 10'h200
      && aperture_delay_code == 10'h000 && !high_speed_single_port)
    else $error("bad values after reset");
endmodule

bind acf_top acf_top_sva u_sva (.clock, .resetn, .serial_csn,
  .serial_data_oe, .sample_valid, .out_data, .out_valid,
  .high_speed_single_port, .aperture_delay_code, .gain_trim_code,
  .offset_trim_code);

/* File: dv/acf_capture.sv */
// downstream capture logic collecting formatted output words
`timescale 1ns/1ps
module acf_capture (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 resetn,
  // formatted ports
  input wire acf_pkg::acf_out_type out_data,
  input wire logic                 out_valid
);
  import acf_pkg::*;
  acf_out_type got [$];

  // take each marked word; no backpressure exists on these ports
  always @(posedge clock) begin
    if (resetn && out_valid === 1'b1)
      got.push_back(out_data);
  end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  import acf_pkg::*;
  logic        clock          = 1'b0;
  logic        resetn         = 1'b0;
  logic        serial_clk     = 1'b0;
  logic        serial_csn     = 1'b1;
  logic        serial_data_in = 1'b0;
  logic        resync_n       = 1'b1;
  logic        sample_valid   = 1'b0;
  logic [11:0] sample_data    = 12'h000;
  logic        serial_data_out, serial_data_oe, out_valid;
  logic        high_speed_single_port;
  logic [9:0]  aperture_delay_code, offset_trim_code;
  logic [7:0]  gain_trim_code, q;
  acf_out_type out_data, o;
  int          fail_count, comparisons, cycles;

  acf_top dut (.clock, .resetn, .serial_clk, .serial_csn, .serial_data_in,
    .serial_data_out, .serial_data_oe, .resync_n, .sample_data,
    .sample_valid, .out_data, .out_valid, .high_speed_single_port,
    .aperture_delay_code, .gain_trim_code, .offset_trim_code);
  acf_capture cap (.clock, .resetn, .out_data, .out_valid);

  // clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one 16-bit frame, msb first; link clock is 16 system clocks
  task automatic xfer(input logic rw, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] r);
    logic [15:0] f;
    f = {rw, a, d};
    r = 8'h00;
    serial_csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_data_in = f[i];
      tick(8);
      if (i < 8) r[i] = serial_data_oe ? serial_data_out : 1'bx;
      serial_clk = 1'b1;
      tick(8);
      serial_clk = 1'b0;
    end
    tick(8);
    serial_csn = 1'b1;
    tick(8);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b0, a, d, r);
  endtask

  // data wire during the read phase carries a fixed 5a filler
  task automatic rd(input logic [6:0] a);
    xfer(1'b1, a, 8'h5a, q);
  endtask

  // back-to-back samples, then let the output settle
  task automatic send(int n, logic [11:0] base);
    cap.got.delete();
    for (int i = 0; i < n; i++) begin
      sample_data = base + 12'(i);
      sample_valid = 1'b1;
      tick(1);
    end
    sample_valid = 1'b0;
    tick(4);
  endtask

  task automatic pop();
    o = cap.got.pop_front();
  endtask

  initial begin
    tick(20);
    resetn = 1'b1;
    tick(4);
    `CHK("gain", 8'h80, gain_trim_code)
    `CHK("offset", 10'h200, offset_trim_code)
    `CHK("delay", 10'h000, aperture_delay_code)
    `CHK("fast", 1'b0, high_speed_single_port)
    rd(OFS_MODE); `CHK("mode", MODE_RESET, q)
    rd(OFS_DELAY_CTRL); `CHK("trim enable", 8'h00, q)
    rd(7'h40); `CHK("unmapped", 8'h00, q)
    $display("test reset done");
    send(4, 12'h100);
    `CHK("pairs", 2, cap.got.size())
    for (int k = 0; k < 2; k++) begin
      pop();
      `CHK("port a", 12'h100 + 12'(2 * k), o.port_a)
      `CHK("port b", 12'h101 + 12'(2 * k), o.port_b)
      `CHK("b valid", 1'b1, o.b_valid)
    end
    wr(OFS_MODE, 8'h00);
    send(3, 12'h200);
    `CHK("singles", 3, cap.got.size())
    for (int k = 0; k < 3; k++) begin
      pop();
      `CHK("port a", 12'h200 + 12'(k), o.port_a)
      `CHK("port b", 12'h000, o.port_b)
      `CHK("b valid", 1'b0, o.b_valid)
    end
    wr(OFS_MODE, 8'h02); `CHK("fast", 1'b1, high_speed_single_port)
    send(2, 12'h400); `CHK("fast words", 2, cap.got.size())
    pop(); `CHK("fast b", 1'b0, o.b_valid)
    $display("test stream done");
    for (int p = 0; p < 2; p++) begin
      wr(OFS_MODE, 8'h04 | 8'(p << 3));
      send(1, 12'h5a5);
      pop();
      `CHK("flat", p ? 12'hfff : 12'h000, o.port_a)
    end
    // two-port ratio, so port b carries the inverted count as well
    wr(OFS_MODE, 8'h15);
    send(34, 12'h000);
    `CHK("align words", 17, cap.got.size())
    pop();
    q = {4'h0, o.port_a[3:0]};
    for (int k = 1; k < 17; k++) begin
      pop();
      `CHK("align a", {3{4'(q[3:0] + k)}}, o.port_a)
      `CHK("align b", ~{3{4'(q[3:0] + k)}}, o.port_b)
    end
    $display("test pattern done");
    wr(OFS_MODE, 8'h00);
    resync_n = 1'b0;
    tick(4);
    send(2, 12'h300); `CHK("held", 0, cap.got.size())
    resync_n = 1'b1;
    tick(4);
    send(1, 12'h301); `CHK("resumed", 1, cap.got.size())
    // trigger mode on the rising edge: idle until that edge arrives
    wr(OFS_MODE, 8'h60);
    resync_n = 1'b0;
    tick(4);
    send(1, 12'h302); `CHK("unarmed", 0, cap.got.size())
    resync_n = 1'b1;
    tick(4);
    send(1, 12'h303); `CHK("armed", 1, cap.got.size())
    rd(OFS_STATUS); `CHK("status", 8'h0d, q)
    $display("test resync done");
    wr(OFS_DELAY_COARS, 8'h03);
    wr(OFS_DELAY_FINE, 8'hff);
    `CHK("delay off", 10'h000, aperture_delay_code)
    rd(OFS_DELAY_COARS); `CHK("coarse kept", 8'h03, q)
    wr(OFS_DELAY_CTRL, 8'h01);
    `CHK("delay max", 10'h3fc, aperture_delay_code)
    wr(OFS_DELAY_FINE, 8'h00);
    `CHK("coarse 3", 10'h2fd, aperture_delay_code)
    wr(OFS_DELAY_COARS, 8'h00);
    wr(OFS_DELAY_FINE, 8'h11);
    `CHK("fine", 10'h011, aperture_delay_code)
    wr(OFS_DELAY_CTRL, 8'h00);
    `CHK("trim off", 10'h000, aperture_delay_code)
    wr(OFS_GAIN, 8'h5a); `CHK("gain", 8'h5a, gain_trim_code)
    wr(OFS_OFFSET_LO, 8'h34);
    wr(OFS_OFFSET_HI, 8'h03); `CHK("offset", 10'h334, offset_trim_code)
    $display("test trims done");
    summarize();
  end
endmodule
